// ===== core/ofc_consts.vh
`ifndef OFC_CONSTS_VH
`define OFC_CONSTS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFC_ADDR_CTRL 8'h00
`define OFC_ADDR_OFFDLY 8'h04
`define OFC_ADDR_LEB 8'h08
`define OFC_ADDR_DEAD 8'h0C
`define OFC_ADDR_STATUS 8'h10
`define OFC_ADDR_ONTIME 8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OFC_CTRL_RUN 0
`define OFC_ST_PHASE_LO 0
`define OFC_ST_PHASE_HI 1
`define OFC_ST_OFFMODE 2
`define OFC_ST_FRONT_LO 3
`define OFC_ST_FRONT_HI 4
`define OFC_ST_TIMER 5
`define OFC_ST_REUSE 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OFC_RST_CTRL 1'b1
`define OFC_RST_OFFDLY 16'h0FA0
`define OFC_RST_LEB 8'h04
`define OFC_RST_DEAD 8'h04

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define OFC_CLK_PERIOD_NS 50
`define OFC_STEP_NS 10
`define OFC_SOFTSTART_CYC 16'h0400

// ----------------------------------------------------------------
// Front-stage output states
// ----------------------------------------------------------------
`define OFC_FS_PULLDOWN 2'h0
`define OFC_FS_REFERENCE 2'h1
`define OFC_FS_BYPASS 2'h2

`endif

// ===== core/ofc_offmode_fsm.v
`timescale 1ns/1ps
`include "ofc_consts.vh"

module ofc_offmode_fsm #(
    parameter SOFTSTART_CYC = `OFC_SOFTSTART_CYC
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Comparator levels
    input wire feedbackBelowOff,
    input wire supplyBelowLow,
    input wire supplyAboveStart,
    // Status
    output reg [1:0] phase_reg,
    output reg offMode_reg,
    output reg pullupConnect_reg,
    output reg selfSupplyOn_reg,
    output reg startupDone_reg
);

    // Startup phases
    localparam WAIT_SUPPLY = 2'd0;
    localparam SOFT_START = 2'd1;
    localparam RUNNING = 2'd2;
    localparam OFF_MODE = 2'd3;

    reg [1:0] phase_next;
    reg [15:0] softCnt_reg;

    // ----------------------------------------------------------------
    // Phase sequencing
    // ----------------------------------------------------------------
    always @* begin
        phase_next = phase_reg;
        case (phase_reg)
            WAIT_SUPPLY: begin
                if (supplyAboveStart) begin
                    phase_next = SOFT_START;
                end
            end
            SOFT_START: begin
                if (softCnt_reg == SOFTSTART_CYC[15:0]) begin
                    phase_next = RUNNING;
                end
            end
            RUNNING: begin
                // Both conditions in the same cycle, never one alone
                if (feedbackBelowOff && supplyBelowLow) begin
                    phase_next = OFF_MODE;
                end
            end
            OFF_MODE: begin
                // Release means a full restart from supply ramp-up
                if (!feedbackBelowOff) begin
                    phase_next = WAIT_SUPPLY;
                end
            end
            default: begin
                phase_next = WAIT_SUPPLY;
            end
        endcase
    end

    // State and side outputs
    always @(posedge clk) begin
        if (reset) begin
            phase_reg <= WAIT_SUPPLY;
            softCnt_reg <= 16'h0000;
            offMode_reg <= 1'b0;
            pullupConnect_reg <= 1'b1;
            selfSupplyOn_reg <= 1'b0;
            startupDone_reg <= 1'b0;
        end else begin
            phase_reg <= phase_next;
            if (phase_reg == SOFT_START) begin
                softCnt_reg <= softCnt_reg + 16'h0001;
            end else begin
                softCnt_reg <= 16'h0000;
            end
            offMode_reg <= (phase_next == OFF_MODE);
            pullupConnect_reg <= (phase_next != OFF_MODE);
            startupDone_reg <= (phase_next == RUNNING);
            // Self-supply hysteresis keeps the phase state alive
            if (phase_next != OFF_MODE) begin
                selfSupplyOn_reg <= 1'b0;
            end else if (supplyBelowLow) begin
                selfSupplyOn_reg <= 1'b1;
            end else if (supplyAboveStart) begin
                selfSupplyOn_reg <= 1'b0;
            end
        end
    end

endmodule // ofc_offmode_fsm

// ===== core/ofc_ontime.v
`timescale 1ns/1ps
`include "ofc_consts.vh"

module ofc_ontime #(
    parameter CNT_W = 12
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Control
    input wire enable,
    input wire [7:0] lebCycles,
    input wire [7:0] deadCycles,
    input wire onTimeCmp,
    // Drives and status
    output reg upperDrive_reg,
    output reg lowerDrive_reg,
    output reg reuse_reg,
    output reg [CNT_W-1:0] lastOnTime_reg
);

    // Switching phases
    localparam DEAD_A = 2'd0;
    localparam UPPER = 2'd1;
    localparam DEAD_B = 2'd2;
    localparam LOWER = 2'd3;

    // One count per step, never below one clock
    localparam STEP_RAW = (`OFC_STEP_NS + `OFC_CLK_PERIOD_NS - 1) / `OFC_CLK_PERIOD_NS;
    localparam STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;

    reg [1:0] phase_reg;
    reg [CNT_W-1:0] onCnt_reg;
    reg [7:0] timer_reg;
    reg [7:0] stepCnt_reg;
    wire stepTick;
    wire blanked;
    wire cntMax;

    assign stepTick = (stepCnt_reg == STEP_CYC[7:0] - 8'd1);
    assign blanked = (timer_reg < lebCycles);
    assign cntMax = (onCnt_reg == {CNT_W{1'b1}});

    // ----------------------------------------------------------------
    // Measure on upper, replay on lower
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (reset) begin
            phase_reg <= DEAD_A;
            onCnt_reg <= {CNT_W{1'b0}};
            timer_reg <= 8'h00;
            stepCnt_reg <= 8'h00;
            upperDrive_reg <= 1'b0;
            lowerDrive_reg <= 1'b0;
            reuse_reg <= 1'b0;
            lastOnTime_reg <= {CNT_W{1'b0}};
        end else if (!enable) begin
            phase_reg <= DEAD_A;
            onCnt_reg <= {CNT_W{1'b0}};
            timer_reg <= 8'h00;
            stepCnt_reg <= 8'h00;
            upperDrive_reg <= 1'b0;
            lowerDrive_reg <= 1'b0;
        end else begin
            stepCnt_reg <= stepTick ? 8'h00 : stepCnt_reg + 8'h01;
            case (phase_reg)
                DEAD_A: begin
                    timer_reg <= timer_reg + 8'h01;
                    if (timer_reg >= deadCycles) begin
                        phase_reg <= UPPER;
                        upperDrive_reg <= 1'b1;
                        onCnt_reg <= {CNT_W{1'b0}};
                        timer_reg <= 8'h00;
                        stepCnt_reg <= 8'h00;
                    end
                end
                UPPER: begin
                    if (blanked) begin
                        // Comparator ignored while switching noise settles
                        timer_reg <= timer_reg + 8'h01;
                    end
                    if (stepTick && !cntMax) begin
                        onCnt_reg <= onCnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                    if (!blanked && onTimeCmp && timer_reg == lebCycles && lastOnTime_reg != {CNT_W{1'b0}}) begin
                        // Already tripped at blank end: sense out of balance
                        onCnt_reg <= lastOnTime_reg;
                        reuse_reg <= 1'b1;
                        phase_reg <= DEAD_B;
                        upperDrive_reg <= 1'b0;
                        timer_reg <= 8'h00;
                    end else if ((!blanked && onTimeCmp) || cntMax) begin
                        lastOnTime_reg <= onCnt_reg;
                        // No step on the trip edge, so lower time equals upper time
                        onCnt_reg <= onCnt_reg;
                        reuse_reg <= 1'b0;
                        phase_reg <= DEAD_B;
                        upperDrive_reg <= 1'b0;
                        timer_reg <= 8'h00;
                    end else if (!blanked) begin
                        // Marks that a trip now comes after blank end
                        timer_reg <= lebCycles + 8'h01;
                    end
                end
                DEAD_B: begin
                    timer_reg <= timer_reg + 8'h01;
                    if (timer_reg >= deadCycles) begin
                        phase_reg <= LOWER;
                        lowerDrive_reg <= 1'b1;
                        stepCnt_reg <= 8'h00;
                    end
                end
                LOWER: begin
                    // Same count replayed down gives symmetric duty
                    if (onCnt_reg == {CNT_W{1'b0}}) begin
                        lowerDrive_reg <= 1'b0;
                        phase_reg <= DEAD_A;
                        timer_reg <= 8'h00;
                    end else if (stepTick) begin
                        onCnt_reg <= onCnt_reg - {{(CNT_W-1){1'b0}}, 1'b1};
                    end
                end
                default: begin
                    phase_reg <= DEAD_A;
                end
            endcase
        end
    end

endmodule // ofc_ontime

// ===== core/ofc_top.v
// Behaviour
// - Off-mode needs low feedback and low supply
// - Feedback release restarts via supply ramp, soft-start
// - Self-supply cycles in off-mode, state kept
// - Feedback pull-up off during off-mode
// - Skip pin only adjusts skip threshold
// - Front-stage output pulled down before startup
// - Pull-down in off-mode or self-supplied protection
// - Enable high gives limited reference level
// - Enable low gives bypass from supply
// - Turn-off request waits for delay timer
// - Delay timer counts up, clears on turn-on
// - Current limited while bypass active
// - Comparator ends upper; lower replays on-time
// - On-time measured in one-clock (50 ns) steps
// - Comparator blanked after upper turn-on
// - Dead time, lower on, count down
// - Stuck comparator reuses last valid on-time
`timescale 1ns/1ps
`include "ofc_consts.vh"

module ofc_top #(
    parameter CNT_W = 12,
    parameter SOFTSTART_CYC = `OFC_SOFTSTART_CYC
) (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Comparator inputs
    input wire feedbackBelowOff,
    input wire supplyBelowLow,
    input wire supplyAboveStart,
    input wire onTimeCmp,
    input wire protectSelfSupply,
    input wire frontStageEnable,
    input wire skipThresholdPin,
    // Front-stage supply output
    output reg frontPullDown,
    output reg frontReference,
    output reg frontBypass,
    output reg frontCurrentLimit,
    // Off-mode and supply
    output wire offModeActive,
    output wire feedbackPullup,
    output wire selfSupplyOn,
    output reg skipEntryAdjust,
    // Half-bridge drives
    output wire upperDrive,
    output wire lowerDrive
);

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    reg runEnable_reg;
    reg [15:0] offDelay_reg;
    reg [7:0] leb_reg;
    reg [7:0] dead_reg;
    reg [1:0] frontState_reg;
    reg [1:0] frontState_next;
    reg [15:0] offTimer_reg;
    reg timerRun_reg;
    reg [31:0] readData;
    wire [1:0] phase;
    wire startupDone;
    wire reuseOnTime;
    wire [CNT_W-1:0] lastOnTime;
    wire forcePullDown;
    wire busReq;
    wire wrEn;
    wire timerDone;

    // ----------------------------------------------------------------
    // Off-mode and startup sequencing
    // ----------------------------------------------------------------
    ofc_offmode_fsm #(
        .SOFTSTART_CYC(SOFTSTART_CYC)
    ) uOffmode (
        .clk(clk),
        .reset(reset),
        .feedbackBelowOff(feedbackBelowOff),
        .supplyBelowLow(supplyBelowLow),
        .supplyAboveStart(supplyAboveStart),
        .phase_reg(phase),
        .offMode_reg(offModeActive),
        .pullupConnect_reg(feedbackPullup),
        .selfSupplyOn_reg(selfSupplyOn),
        .startupDone_reg(startupDone)
    );

    // ----------------------------------------------------------------
    // On-time modulation
    // ----------------------------------------------------------------
    ofc_ontime #(
        .CNT_W(CNT_W)
    ) uOntime (
        .clk(clk),
        .reset(reset),
        .enable(startupDone & runEnable_reg),
        .lebCycles(leb_reg),
        .deadCycles(dead_reg),
        .onTimeCmp(onTimeCmp),
        .upperDrive_reg(upperDrive),
        .lowerDrive_reg(lowerDrive),
        .reuse_reg(reuseOnTime),
        .lastOnTime_reg(lastOnTime)
    );

    // ----------------------------------------------------------------
    // Skip pin path
    // ----------------------------------------------------------------
    // Skip pin feeds only the skip threshold, never off-mode
    always @(posedge clk) begin
        if (reset) begin
            skipEntryAdjust <= 1'b0;
        end else begin
            skipEntryAdjust <= skipThresholdPin;
        end
    end

    // ----------------------------------------------------------------
    // Front-stage supply output
    // ----------------------------------------------------------------
    // Pull-down outranks the enable input
    assign forcePullDown = !startupDone || offModeActive || protectSelfSupply;
    assign timerDone = (offTimer_reg >= offDelay_reg);

    always @* begin
        frontState_next = frontState_reg;
        case (frontState_reg)
            `OFC_FS_PULLDOWN: begin
                // No delay on leaving pull-down, even when off-mode or protection forced it
                if (!forcePullDown) begin
                    frontState_next = frontStageEnable ? `OFC_FS_REFERENCE : `OFC_FS_BYPASS;
                end
            end
            `OFC_FS_REFERENCE: begin
                if (!frontStageEnable) begin
                    frontState_next = `OFC_FS_BYPASS;
                end
            end
            `OFC_FS_BYPASS: begin
                if (frontStageEnable && timerDone) begin
                    frontState_next = `OFC_FS_REFERENCE;
                end
            end
            default: begin
                frontState_next = `OFC_FS_PULLDOWN;
            end
        endcase
        if (forcePullDown) begin
            frontState_next = `OFC_FS_PULLDOWN;
        end
    end

    // Turn-off delay: counts only upward, clears on turn-on
    always @(posedge clk) begin
        if (reset) begin
            offTimer_reg <= 16'h0000;
            timerRun_reg <= 1'b0;
        end else if (!frontStageEnable || frontState_reg != `OFC_FS_BYPASS) begin
            offTimer_reg <= 16'h0000;
            timerRun_reg <= 1'b0;
        end else begin
            timerRun_reg <= !timerDone;
            if (!timerDone) begin
                offTimer_reg <= offTimer_reg + 16'h0001;
            end
        end
    end

    // Pin controls: pull-down, reference and bypass one-hot; current limit high outside pull-down
    always @(posedge clk) begin
        if (reset) begin
            frontState_reg <= `OFC_FS_PULLDOWN;
            frontPullDown <= 1'b1;
            frontReference <= 1'b0;
            frontBypass <= 1'b0;
            frontCurrentLimit <= 1'b0;
        end else begin
            frontState_reg <= frontState_next;
            frontPullDown <= (frontState_next == `OFC_FS_PULLDOWN);
            frontReference <= (frontState_next == `OFC_FS_REFERENCE);
            frontBypass <= (frontState_next == `OFC_FS_BYPASS);
            // Limit also protects the bypass switch while charging
            frontCurrentLimit <= (frontState_next != `OFC_FS_PULLDOWN);
        end
    end

    // ----------------------------------------------------------------
    // Wishbone register slave
    // ----------------------------------------------------------------
    // Single-cycle answer; ack drops the cycle after it is given
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wrEn = busReq && wb_we_i;

    // Read mux, unmapped addresses read zero
    always @* begin
        readData = 32'h0000_0000;
        case (wb_adr_i)
            `OFC_ADDR_CTRL: begin
                readData[`OFC_CTRL_RUN] = runEnable_reg;
            end
            `OFC_ADDR_OFFDLY: begin
                readData[15:0] = offDelay_reg;
            end
            `OFC_ADDR_LEB: begin
                readData[7:0] = leb_reg;
            end
            `OFC_ADDR_DEAD: begin
                readData[7:0] = dead_reg;
            end
            `OFC_ADDR_STATUS: begin
                readData[`OFC_ST_PHASE_HI:`OFC_ST_PHASE_LO] = phase;
                readData[`OFC_ST_OFFMODE] = offModeActive;
                readData[`OFC_ST_FRONT_HI:`OFC_ST_FRONT_LO] = frontState_reg;
                readData[`OFC_ST_TIMER] = timerRun_reg;
                readData[`OFC_ST_REUSE] = reuseOnTime;
            end
            `OFC_ADDR_ONTIME: begin
                readData[CNT_W-1:0] = lastOnTime;
            end
            default: begin
                readData = 32'h0000_0000;
            end
        endcase
    end

    // Bus handshake and writable registers
    always @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            runEnable_reg <= `OFC_RST_CTRL;
            offDelay_reg <= `OFC_RST_OFFDLY;
            leb_reg <= `OFC_RST_LEB;
            dead_reg <= `OFC_RST_DEAD;
        end else begin
            wb_ack_o <= busReq;
            wb_dat_o <= busReq ? readData : 32'h0000_0000;
            if (wrEn) begin
                case (wb_adr_i)
                    `OFC_ADDR_CTRL: begin
                        if (wb_sel_i[0]) begin
                            runEnable_reg <= wb_dat_i[`OFC_CTRL_RUN];
                        end
                    end
                    `OFC_ADDR_OFFDLY: begin
                        if (wb_sel_i[0]) begin
                            offDelay_reg[7:0] <= wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            offDelay_reg[15:8] <= wb_dat_i[15:8];
                        end
                    end
                    `OFC_ADDR_LEB: begin
                        if (wb_sel_i[0]) begin
                            leb_reg <= wb_dat_i[7:0];
                        end
                    end
                    `OFC_ADDR_DEAD: begin
                        if (wb_sel_i[0]) begin
                            dead_reg <= wb_dat_i[7:0];
                        end
                    end
                    default: begin
                        // Read-only or unmapped: write ignored, still acked
                    end
                endcase
            end
        end
    end

endmodule // ofc_top

// ===== tb/ofc_far_side.sv
`timescale 1ns/1ps
// ----------------------------------------
// Secondary off-mode controller model
// ----------------------------------------
module ofc_far_side (
    // Clock
    input wire clk,
    // Application wish to sleep
    input wire offWanted,
    // Optocoupler pulling the feedback pin low
    output reg feedbackBelowOff
);
    // Opto held for the whole off period, never biased otherwise
    initial feedbackBelowOff = 1'b0;
    always @(posedge clk) begin
        feedbackBelowOff <= offWanted;
    end
endmodule // ofc_far_side

// ===== tb/ofc_top_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Port-level checker
// ----------------------------------------
module ofc_top_sva (
    // Clock and reset
    input wire clk,
    input wire reset,
    // Bus handshake
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    // Causes
    input wire feedbackBelowOff,
    input wire supplyBelowLow,
    input wire protectSelfSupply,
    input wire skipThresholdPin,
    // Effects
    input wire frontPullDown,
    input wire frontReference,
    input wire frontBypass,
    input wire frontCurrentLimit,
    input wire offModeActive,
    input wire feedbackPullup,
    input wire skipEntryAdjust,
    input wire upperDrive,
    input wire lowerDrive
);
    // One domain, so clock and reset given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    fs_onehot_a: assert property ($onehot({frontPullDown, frontReference, frontBypass}))
        else $error("front stage not in exactly one state");
    drive_excl_a: assert property (!(upperDrive && lowerDrive))
        else $error("both switches driven");
    ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    off_entry_a: assert property ($rose(offModeActive) |-> $past(feedbackBelowOff && supplyBelowLow))
        else $error("off-mode entered without both conditions");
    pullup_off_a: assert property (offModeActive |-> !feedbackPullup)
        else $error("pull-up connected in off-mode");
    pullup_back_a: assert property ($fell(offModeActive) |-> feedbackPullup)
        else $error("pull-up not restored at off-mode exit");
    force_pd_a: assert property (offModeActive || protectSelfSupply |=> frontPullDown)
        else $error("pull-down not forced");
    bypass_lim_a: assert property (frontBypass |-> frontCurrentLimit)
        else $error("bypass without current limit");
    skip_copy_a: assert property (!$past(reset) |-> skipEntryAdjust == $past(skipThresholdPin))
        else $error("skip adjust not following its pin");
endmodule // ofc_top_sva

bind ofc_top ofc_top_sva chk (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .feedbackBelowOff,
    .supplyBelowLow, .protectSelfSupply, .skipThresholdPin, .frontPullDown, .frontReference,
    .frontBypass, .frontCurrentLimit, .offModeActive, .feedbackPullup, .skipEntryAdjust,
    .upperDrive, .lowerDrive);

// ===== tb/ofc_top_test.sv
`timescale 1ns/1ps
`include "ofc_consts.vh"
module ofc_top_test;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic clk = 1'b0, reset = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000, rdat;
    logic supplyBelowLow = 1'b0, supplyAboveStart = 1'b0, onTimeCmp = 1'b0, protectSelfSupply = 1'b0;
    logic frontStageEnable = 1'b0, skipThresholdPin = 1'b0, offWanted = 1'b0;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, feedbackBelowOff, frontPullDown, frontReference, frontBypass, frontCurrentLimit;
    wire offModeActive, feedbackPullup, selfSupplyOn, skipEntryAdjust, upperDrive, lowerDrive;
    // Bit order: off, pulldown, reference, bypass, upper, lower
    wire [5:0] obs = {lowerDrive, upperDrive, frontBypass, frontReference, frontPullDown, offModeActive};
    int miscompares = 0, checksDone = 0, u, l, ot;

    always #25 clk = ~clk;

    ofc_top #(.SOFTSTART_CYC(8)) uut (.clk, .reset, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .feedbackBelowOff, .supplyBelowLow, .supplyAboveStart,
        .onTimeCmp, .protectSelfSupply, .frontStageEnable, .skipThresholdPin, .frontPullDown,
        .frontReference, .frontBypass, .frontCurrentLimit, .offModeActive, .feedbackPullup,
        .selfSupplyOn, .skipEntryAdjust, .upperDrive, .lowerDrive);
    ofc_far_side far (.clk, .offWanted, .feedbackBelowOff);

    task print_verdict;
        if (miscompares == 0 && checksDone > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checksDone++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Waits are bounded; running out ends the run
    task waitSig(input int idx, input logic v, input int lim);
        for (int n = 0; obs[idx] !== v; n++) begin
            if (n == lim) begin
                chk("wait", 1, 0);
                print_verdict();
            end
            @(posedge clk);
        end
    endtask

    // Classic cycle: hold until ack, then one idle cycle
    task wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        for (int n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wb_ack_o === 1'b1)
                break;
        end
        chk("ack", 1, wb_ack_o);
        if (wb_ack_o !== 1'b1) print_verdict();
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    // High-time of a drive, optionally tripping the comparator at a count
    task hiLen(input int idx, input int trip, output int len);
        waitSig(idx, 1, 9000);
        len = 1;
        for (int n = 0; n < 4000; n++) begin
            if (len == trip)
                onTimeCmp <= 1'b1;
            @(posedge clk);
            if (obs[idx] !== 1'b1)
                break;
            len++;
        end
        waitSig(idx, 0, 0);
    endtask

    task trial(input int d);
        waitSig(4, 0, 9000);
        hiLen(4, d, u);
        onTimeCmp <= 1'b0;
        hiLen(5, 0, l);
        wb(0, `OFC_ADDR_ONTIME, 0);
        chk("lower", u, l);
        chk("ontime", d, rdat);
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        wb(0, `OFC_ADDR_CTRL, 0);
        chk("ctrl", `OFC_RST_CTRL, rdat);
        wb(0, `OFC_ADDR_LEB, 0);
        chk("leb", `OFC_RST_LEB, rdat);
        wb(0, `OFC_ADDR_DEAD, 0);
        chk("dead", `OFC_RST_DEAD, rdat);
        wb(0, `OFC_ADDR_OFFDLY, 0);
        chk("offdly", `OFC_RST_OFFDLY, rdat);
        wb(1, `OFC_ADDR_OFFDLY, 32'h0000_0005);
        wb(1, 8'h1C, 32'hFFFF_FFFF);
        wb(0, 8'h1C, 0);
        chk("unmapped", 0, rdat);
        chk("predown", 1, frontPullDown);
        supplyAboveStart <= 1'b1;
        waitSig(1, 0, 60);
        chk("bypass", 1, frontBypass);
        frontStageEnable <= 1'b1;
        repeat (4) @(posedge clk);
        frontStageEnable <= 1'b0;
        repeat (2) @(posedge clk);
        frontStageEnable <= 1'b1;
        repeat (4) @(posedge clk);
        chk("held", 1, frontBypass);
        waitSig(2, 1, 8);
        chk("limit", 1, frontCurrentLimit);
        trial(10);
        ot = rdat;
        trial(20);
        chk("step", ot + 10, rdat);
        ot = rdat;
        onTimeCmp <= 1'b1;
        waitSig(4, 0, 400);
        hiLen(4, 0, u);
        hiLen(5, 0, l);
        chk("blank", 1, u >= `OFC_RST_LEB);
        chk("replay", ot + 1, l);
        wb(0, `OFC_ADDR_STATUS, 0);
        chk("reuse", 1, rdat[`OFC_ST_REUSE]);
        onTimeCmp <= 1'b0;
        offWanted <= 1'b1;
        repeat (5) @(posedge clk);
        chk("alone", 0, offModeActive);
        supplyBelowLow <= 1'b1;
        supplyAboveStart <= 1'b0;
        waitSig(0, 1, 5);
        repeat (2) @(posedge clk);
        chk("pullup", 0, feedbackPullup);
        chk("offdown", 1, frontPullDown);
        chk("dss", 1, selfSupplyOn);
        supplyBelowLow <= 1'b0;
        supplyAboveStart <= 1'b1;
        repeat (3) @(posedge clk);
        chk("charged", 0, selfSupplyOn);
        chk("kept", 1, offModeActive);
        supplyAboveStart <= 1'b0;
        offWanted <= 1'b0;
        waitSig(0, 0, 5);
        repeat (20) @(posedge clk);
        chk("waitvcc", 1, frontPullDown);
        supplyAboveStart <= 1'b1;
        waitSig(1, 0, 60);
        protectSelfSupply <= 1'b1;
        repeat (3) @(posedge clk);
        chk("protect", 1, frontPullDown);
        protectSelfSupply <= 1'b0;
        skipThresholdPin <= 1'b1;
        repeat (3) @(posedge clk);
        chk("skip", 1, skipEntryAdjust);
        chk("skipoff", 0, offModeActive);
        print_verdict();
    end
endmodule // ofc_top_test
